//--- include/cawd_defs.svh
// constants of the counter array watchdog: offsets, bit positions, reset values, dividers
// assumes it is included by bare name in every file that needs it
`ifndef CAWD_DEFS_SVH
`define CAWD_DEFS_SVH

`define CAWD_ADDR_CTRL 8'hd8
`define CAWD_ADDR_MODE 8'hd9
`define CAWD_ADDR_M2MODE 8'hdc
`define CAWD_ADDR_CNTL 8'he9
`define CAWD_ADDR_CNTH 8'hf9
`define CAWD_ADDR_CMPL2 8'heb
`define CAWD_ADDR_CMPH2 8'hfb

`define CAWD_CTRL_OVF 7
`define CAWD_CTRL_RUN 6
`define CAWD_CTRL_F2 2

`define CAWD_MODE_IDLE 7
`define CAWD_MODE_WDE 6
`define CAWD_MODE_LCK 5
`define CAWD_MODE_CPS_HI 3
`define CAWD_MODE_CPS_LO 1
`define CAWD_MODE_OVFIE 0

`define CAWD_M2_CMPEN 6
`define CAWD_M2_MATCH 3
`define CAWD_M2_IRQEN 0

`define CAWD_CTRL_RST 8'h00
`define CAWD_MODE_RST 8'h40
`define CAWD_CPS_RST 3'h0
`define CAWD_CNT_RST 16'h0000
`define CAWD_CMP_RST 8'h00
`define CAWD_M2MODE_RST 8'h00
`define CAWD_M2_SWTIMER 8'h48

`define CAWD_DIV12_LAST 4'hb
`define CAWD_DIV4_LAST 2'h3
`define CAWD_DIV8_LAST 3'h7

`endif

//--- include/cawd_pkg.sv
// types of the counter array watchdog
// assumes nothing of its surroundings
package cawd_pkg;
    typedef enum logic [2:0] {
        src_div12,
        src_div4,
        src_timer0,
        src_ext_fall,
        src_sys,
        src_ext_div8,
        src_rtc_div8,
        src_reserved
    } cawd_clksrc_t;
endpackage

//--- verilog/cawd_timebase.sv
// counter timebase: one-cycle tick from the selected source
// assumes pin inputs are asynchronous and timer0_ovf_i is on clk_i
`include "cawd_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module cawd_timebase (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // selection
    input wire logic [2:0] sel_i,
    // sources
    input wire logic timer0_ovf_i,
    input wire logic eci_i,
    input wire logic ext_clk_i,
    input wire logic rtc_clk_i,
    // tick
    output logic tick_o
);
    logic [2:0] pins;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [3:0] div12_q;
    logic [1:0] div4_q;
    logic [2:0] div8_q [1:0];
    logic [1:0] div8_hit;
    logic tick_d;
    cawd_pkg::cawd_clksrc_t src;

    assign pins = {eci_i, ext_clk_i, rtc_clk_i};
    assign src = cawd_pkg::cawd_clksrc_t'(sel_i);

    // two-flop synchronisers, third flop only for edge detection
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_sync
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                    s3_q[i] <= 1'b0;
                end else if (ce_i) begin
                    s1_q[i] <= pins[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                end
            end
        end
        // rising-edge divide-by-8 for rtc (0) and external clock (1)
        for (i = 0; i < 2; i = i + 1) begin : g_div8
            assign div8_hit[i] = s2_q[i] && !s3_q[i] && (div8_q[i] == `CAWD_DIV8_LAST);
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    div8_q[i] <= 3'h0;
                end else if (ce_i && s2_q[i] && !s3_q[i]) begin
                    div8_q[i] <= div8_q[i] + 3'h1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div12_q <= 4'h0;
            div4_q <= 2'h0;
        end else if (ce_i) begin
            div12_q <= (div12_q == `CAWD_DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
            div4_q <= div4_q + 2'h1;
        end
    end

    always_comb begin
        case (src)
            cawd_pkg::src_div12: tick_d = (div12_q == `CAWD_DIV12_LAST);
            cawd_pkg::src_div4: tick_d = (div4_q == `CAWD_DIV4_LAST);
            cawd_pkg::src_timer0: tick_d = timer0_ovf_i;
            cawd_pkg::src_ext_fall: tick_d = !s2_q[2] && s3_q[2];
            cawd_pkg::src_sys: tick_d = 1'b1;
            cawd_pkg::src_ext_div8: tick_d = div8_hit[1];
            cawd_pkg::src_rtc_div8: tick_d = div8_hit[0];
            default: tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_o <= 1'b0;
        end else if (ce_i) begin
            tick_o <= tick_d;
        end
    end
endmodule
`default_nettype wire

//--- verilog/cawd_top.sv
// counter array watchdog: 16-bit counter, control and mode registers, module 2 watchdog
// assumes a byte-wide special-function register port on clk_i and a system reset
// controller that consumes wd_reset_o and pulls rst_n_i
`include "cawd_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module cawd_top (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // special-function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_we_i,
    output logic [7:0] sfr_rdata_o,
    // core status
    input wire logic idle_i,
    // timebase sources
    input wire logic timer0_ovf_i,
    input wire logic eci_i,
    input wire logic ext_clk_i,
    input wire logic rtc_clk_i,
    // modules 0 and 1
    input wire logic [1:0] match_set_i,
    input wire logic [1:0] match_irq_en_i,
    // results
    output logic irq_o,
    output logic wd_reset_o,
    output logic wd_enabled_o
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic tick;

    // register state
    logic ovf_q;
    logic cr_q;
    logic [2:0] flag_q;
    logic idle_suspend_q;
    logic wde_q;
    logic lck_q;
    logic [2:0] cps_q;
    logic ecf_q;
    logic [7:0] m2mode_q;
    logic [15:0] cnt_q;
    logic [7:0] cmpl_q;
    logic [7:0] cmph_q;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    cawd_timebase u_timebase (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .sel_i(cps_q),
        .timer0_ovf_i(timer0_ovf_i),
        .eci_i(eci_i),
        .ext_clk_i(ext_clk_i),
        .rtc_clk_i(rtc_clk_i),
        .tick_o(tick)
    );

    // address decode
    wire wr_ctrl = sfr_we_i && (sfr_addr_i == `CAWD_ADDR_CTRL);
    wire wr_mode = sfr_we_i && (sfr_addr_i == `CAWD_ADDR_MODE);
    wire wr_m2mode = sfr_we_i && (sfr_addr_i == `CAWD_ADDR_M2MODE);
    wire wr_cntl = sfr_we_i && (sfr_addr_i == `CAWD_ADDR_CNTL);
    wire wr_cnth = sfr_we_i && (sfr_addr_i == `CAWD_ADDR_CNTH);
    wire wr_cmpl = sfr_we_i && (sfr_addr_i == `CAWD_ADDR_CMPL2);
    wire wr_cmph = sfr_we_i && (sfr_addr_i == `CAWD_ADDR_CMPH2);

    // counter stepping
    wire run = cr_q || wde_q;
    wire susp = idle_suspend_q && idle_i;
    wire step = tick && run && !susp;
    wire [15:0] cnt_inc = cnt_q + 16'h0001;
    wire [15:0] cnt_step = step ? cnt_inc : cnt_q;
    wire low_ovf = step && (cnt_q[7:0] == 8'hff);
    wire wrap = step && (cnt_q == 16'hffff);
    wire [7:0] cntl_d = (wr_cntl && !wde_q) ? sfr_wdata_i : cnt_step[7:0];
    wire [7:0] cnth_d = (wr_cnth && !wde_q) ? sfr_wdata_i : cnt_step[15:8];

    // module 2: software timer compare, forced while the watchdog runs
    wire [7:0] m2_eff = wde_q ? `CAWD_M2_SWTIMER : m2mode_q;
    wire m2_hit = step && m2_eff[`CAWD_M2_CMPEN] && m2_eff[`CAWD_M2_MATCH]
                  && (cnt_q == {cmph_q, cmpl_q});
    // refresh: the written byte is discarded; deadline is offset plus one overflows ahead
    wire [7:0] cmph_d = wr_cmph ? cnt_q[15:8] + cmpl_q : cmph_q;

    // watchdog reset causes
    wire timeout = wde_q && low_ovf && (cmph_q == cnt_q[15:8]);
    wire force_rst = wde_q && wr_ctrl && sfr_wdata_i[`CAWD_CTRL_F2];

    // enable and lock; lock also enables and can only be cleared by reset
    wire lck_d = lck_q || (wr_mode && sfr_wdata_i[`CAWD_MODE_LCK]);
    wire wde_set = sfr_wdata_i[`CAWD_MODE_WDE] || sfr_wdata_i[`CAWD_MODE_LCK];
    wire wde_d = lck_q ? 1'b1 : (wr_mode ? wde_set : wde_q);
    wire cfg_wr = wr_mode && !wde_q;

    // flags: hardware set wins over a software write of zero
    wire [2:0] flag_set = {m2_hit, match_set_i};
    wire [2:0] flag_d;
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_flag
            assign flag_d[i] = flag_set[i] || (wr_ctrl ? sfr_wdata_i[i] : flag_q[i]);
        end
    endgenerate
    wire ovf_d = wrap || (wr_ctrl ? sfr_wdata_i[`CAWD_CTRL_OVF] : ovf_q);

    wire irq_d = (ovf_q && ecf_q) || (flag_q[2] && m2_eff[`CAWD_M2_IRQEN])
                 || ((flag_q[1:0] & match_irq_en_i) != 2'b00);

    // read mux; reserved bits read zero, run bit shows only the software value
    wire [7:0] rd_ctrl = {ovf_q, cr_q, 3'b000, flag_q};
    wire [7:0] rd_mode = {idle_suspend_q, wde_q, lck_q, 1'b0, cps_q, ecf_q};
    wire [7:0] rd_mux = (sfr_addr_i == `CAWD_ADDR_CTRL) ? rd_ctrl :
                        (sfr_addr_i == `CAWD_ADDR_MODE) ? rd_mode :
                        (sfr_addr_i == `CAWD_ADDR_M2MODE) ? m2mode_q :
                        (sfr_addr_i == `CAWD_ADDR_CNTL) ? cnt_q[7:0] :
                        (sfr_addr_i == `CAWD_ADDR_CNTH) ? cnt_q[15:8] :
                        (sfr_addr_i == `CAWD_ADDR_CMPL2) ? cmpl_q :
                        (sfr_addr_i == `CAWD_ADDR_CMPH2) ? cmph_q : 8'h00;

    // control register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
            cr_q <= 1'b0;
            flag_q <= 3'h0;
        end else if (ce_i) begin
            ovf_q <= ovf_d;
            cr_q <= wr_ctrl ? sfr_wdata_i[`CAWD_CTRL_RUN] : cr_q;
            flag_q <= flag_d;
        end
    end

    // mode register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            idle_suspend_q <= 1'b0;
            wde_q <= 1'b1;
            lck_q <= 1'b0;
            cps_q <= `CAWD_CPS_RST;
            ecf_q <= 1'b0;
        end else if (ce_i) begin
            wde_q <= wde_d;
            lck_q <= lck_d;
            if (cfg_wr) begin
                idle_suspend_q <= sfr_wdata_i[`CAWD_MODE_IDLE];
                cps_q <= sfr_wdata_i[`CAWD_MODE_CPS_HI:`CAWD_MODE_CPS_LO];
            end
            if (wr_mode) begin
                ecf_q <= sfr_wdata_i[`CAWD_MODE_OVFIE];
            end
        end
    end

    // counter and module 2
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `CAWD_CNT_RST;
            cmpl_q <= `CAWD_CMP_RST;
            cmph_q <= `CAWD_CMP_RST;
            m2mode_q <= `CAWD_M2MODE_RST;
        end else if (ce_i) begin
            cnt_q <= {cnth_d, cntl_d};
            cmph_q <= cmph_d;
            if (wr_cmpl) begin
                cmpl_q <= sfr_wdata_i;
            end
            if (wr_m2mode && !wde_q) begin
                m2mode_q <= sfr_wdata_i;
            end
        end
    end

    // outputs
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_o <= 8'h00;
            irq_o <= 1'b0;
            wd_reset_o <= 1'b0;
            wd_enabled_o <= 1'b1;
        end else if (ce_i) begin
            sfr_rdata_o <= rd_mux;
            irq_o <= irq_d;
            wd_reset_o <= timeout || force_rst;
            wd_enabled_o <= wde_d;
        end
    end

    a_wd_counter_runs: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ce_i && wde_q && tick && !susp |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not step while watchdog enabled");

    a_cnt_write_block: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ce_i && wde_q && (wr_cntl || wr_cnth) && !step |=> cnt_q == $past(cnt_q))
        else $error("counter write taken while watchdog enabled");

    a_cfg_frozen: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wde_q |=> cps_q == $past(cps_q) && idle_suspend_q == $past(idle_suspend_q))
        else $error("clock source or idle bit changed while watchdog enabled");

    a_m2_mode_frozen: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        wde_q |=> m2mode_q == $past(m2mode_q))
        else $error("module 2 mode changed while watchdog enabled");

    a_run_readback: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ce_i && sfr_addr_i == `CAWD_ADDR_CTRL |=> sfr_rdata_o[6] == $past(cr_q))
        else $error("run bit read back does not match software value");

    a_wd_timeout: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ce_i && wde_q && step && cnt_q[7:0] == 8'hff && cmph_q == cnt_q[15:8]
        |=> wd_reset_o)
        else $error("watchdog timeout did not reset");

    a_no_false_reset: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ce_i && !wde_q |=> !wd_reset_o)
        else $error("reset issued with watchdog disabled");

    a_refresh_load: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ce_i && wr_cmph |=> cmph_q == $past(cnt_q[15:8]) + $past(cmpl_q))
        else $error("refresh did not load high byte plus offset");

    a_force_reset: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ce_i && wde_q && wr_ctrl && sfr_wdata_i[2] |=> wd_reset_o)
        else $error("flag 2 write did not force reset");

    a_lock_holds: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        lck_q |=> wde_q && lck_q)
        else $error("locked watchdog was disabled");

    a_ovf_set: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ce_i && step && cnt_q == 16'hffff && !wr_cntl && !wr_cnth
        |=> ovf_q && cnt_q == 16'h0000)
        else $error("wrap did not set overflow flag");

    a_idle_halt: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ce_i && idle_suspend_q && idle_i && !wr_cntl && !wr_cnth |=> cnt_q == $past(cnt_q))
        else $error("counter moved during suspended idle");
endmodule
`default_nettype wire

//--- dv/test_cawd_top.sv
// testbench of the counter array watchdog: register sequences with expected values
// assumes cawd_top and its constants header; the bench drives every input itself
`include "cawd_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module test_cawd_top;
    localparam logic [7:0] A_CTL = `CAWD_ADDR_CTRL;
    localparam logic [7:0] A_MD = `CAWD_ADDR_MODE;
    localparam logic [7:0] A_M2 = `CAWD_ADDR_M2MODE;
    localparam logic [7:0] A_CL = `CAWD_ADDR_CNTL;
    localparam logic [7:0] A_CH = `CAWD_ADDR_CNTH;
    localparam logic [7:0] A_OFS = `CAWD_ADDR_CMPL2;
    localparam logic [7:0] A_REF = `CAWD_ADDR_CMPH2;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic sfr_we_i = 1'b0;
    logic idle_i = 1'b0;
    logic timer0_ovf_i = 1'b0;
    logic eci_i = 1'b1;
    logic ce_i = 1'b1;
    logic ext_clk_i = 1'b0;
    logic rtc_clk_i = 1'b0;
    logic [1:0] match_set_i = 2'h0;
    logic [1:0] match_irq_en_i = 2'h1;
    logic [7:0] sfr_rdata_o;
    logic irq_o;
    logic wd_reset_o;
    logic wd_enabled_o;
    int err_count = 0;
    int n_compared = 0;
    int n;
    logic [7:0] r1;
    logic [7:0] r2;

    always #20 clk_i = ~clk_i;

    cawd_top u_dut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i),
        .sfr_we_i(sfr_we_i),
        .sfr_rdata_o(sfr_rdata_o),
        .idle_i(idle_i),
        .timer0_ovf_i(timer0_ovf_i),
        .eci_i(eci_i),
        .ext_clk_i(ext_clk_i),
        .rtc_clk_i(rtc_clk_i),
        .match_set_i(match_set_i),
        .match_irq_en_i(match_irq_en_i),
        .irq_o(irq_o),
        .wd_reset_o(wd_reset_o),
        .wd_enabled_o(wd_enabled_o)
    );

    task automatic give_verdict;
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one write: strobe high for exactly one edge
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i <= ad;
        sfr_wdata_i <= d;
        sfr_we_i <= 1'b1;
        @(posedge clk_i);
        sfr_we_i <= 1'b0;
    endtask

    // read data is registered: valid after the edge that sampled the address
    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i <= ad;
        @(posedge clk_i);
        @(negedge clk_i);
        d = sfr_rdata_o;
    endtask

    task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] v;
        rd(ad, v);
        chk({8'h00, v}, {8'h00, exp});
    endtask

    task automatic do_reset;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask

    // watchdog off, source selected, counter preset, then run
    task automatic setup(input logic [7:0] md, input logic [15:0] cnt);
        wr(A_MD, md);
        wr(A_CL, cnt[7:0]);
        wr(A_CH, cnt[15:8]);
        wr(A_CTL, 8'h40);
    endtask

    // run a timed window on one source and check the tick count
    task automatic rate(input logic [2:0] src, input int lo, input int hi);
        setup({4'h0, src, 1'b0}, 16'h0000);
        repeat (118) @(posedge clk_i);
        wr(A_CTL, 8'h00);
        rd(A_CL, r1);
        chk(16'(r1 >= lo && r1 <= hi), 16'h0001);
    endtask

    // pin select: 0 eci low, 1 timer0, 2 match 0, 3 match 1, 4 ext clock, 5 rtc clock
    task automatic drive_pin(input int sel, input logic on);
        case (sel)
            0: eci_i <= !on;
            1: timer0_ovf_i <= on;
            2: match_set_i[0] <= on;
            3: match_set_i[1] <= on;
            4: ext_clk_i <= on;
            default: rtc_clk_i <= on;
        endcase
    endtask

    // one-cycle pulse on the selected pin, then time for the synchronisers
    task automatic pulse(input int sel);
        @(posedge clk_i);
        drive_pin(sel, 1'b1);
        @(posedge clk_i);
        drive_pin(sel, 1'b0);
        repeat (6) @(posedge clk_i);
    endtask

    initial begin
        #1_000_000;
        err_count++;
        give_verdict;
    end

    initial begin
        do_reset;
        chk({15'h0, wd_enabled_o}, 16'h0001);
        rchk(A_MD, 8'h40);
        rchk(A_OFS, 8'h00);
        wr(A_CTL, 8'h00);
        rchk(A_CTL, 8'h00);
        rd(A_CL, r1);
        repeat (30) @(posedge clk_i);
        rd(A_CL, r2);
        chk(16'(r1 !== r2), 16'h0001);
        wr(A_CH, 8'h80);
        rchk(A_CH, 8'h00);
        wr(A_MD, 8'hc8);
        rchk(A_MD, 8'h40);
        wr(A_M2, 8'h01);
        wr(A_MD, 8'h00);
        @(negedge clk_i);
        chk({15'h0, wd_enabled_o}, 16'h0000);
        rchk(A_M2, 8'h00);
        wr(A_CL, 8'h5a);
        rchk(A_CL, 8'h5a);
        // a write with the clock enable low is not taken
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(A_CL, 8'h11);
        ce_i <= 1'b1;
        rchk(A_CL, 8'h5a);
        rate(3'h0, 8, 11);
        rate(3'h1, 28, 32);
        rate(3'h4, 116, 124);
        // external falling edges: four of them
        setup(8'h06, 16'h0000);
        repeat (4) pulse(0);
        wr(A_CTL, 8'h00);
        rchk(A_CL, 8'h04);
        // external clock and rtc: eight rising edges give one tick
        setup(8'h0a, 16'h0000);
        repeat (8) pulse(4);
        wr(A_CTL, 8'h00);
        rchk(A_CL, 8'h01);
        setup(8'h0c, 16'h0000);
        repeat (8) pulse(5);
        wr(A_CTL, 8'h00);
        rchk(A_CL, 8'h01);
        // timer0 ticks across the full wrap
        setup(8'h04, 16'hfffe);
        repeat (3) pulse(1);
        rchk(A_CTL, 8'hc0);
        rchk(A_CL, 8'h01);
        rchk(A_CH, 8'h00);
        wr(A_MD, 8'h05);
        repeat (2) @(negedge clk_i);
        chk({15'h0, irq_o}, 16'h0001);
        wr(A_CTL, 8'h00);
        rchk(A_CTL, 8'h00);
        pulse(2);
        pulse(3);
        rchk(A_CTL, 8'h03);
        chk({15'h0, irq_o}, 16'h0001);
        wr(A_CTL, 8'h00);
        repeat (2) @(negedge clk_i);
        chk({15'h0, irq_o}, 16'h0000);
        // idle suspend on the system clock source
        setup(8'h88, 16'h0000);
        idle_i <= 1'b1;
        rd(A_CL, r1);
        repeat (10) @(posedge clk_i);
        rd(A_CL, r2);
        chk({8'h00, r2}, {8'h00, r1});
        @(posedge clk_i);
        idle_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rd(A_CL, r2);
        chk(16'(r1 !== r2), 16'h0001);
        wr(A_CTL, 8'h00);
        // timeout with offset two on the system clock
        setup(8'h08, 16'h0000);
        wr(A_CTL, 8'h00);
        wr(A_OFS, 8'h02);
        wr(A_MD, 8'h48);
        @(negedge clk_i);
        chk({15'h0, wd_enabled_o}, 16'h0001);
        wr(A_REF, 8'h77);
        rchk(A_REF, 8'h02);
        n = 0;
        while (wd_reset_o !== 1'b1 && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        chk(16'(n >= 730 && n <= 775), 16'h0001);
        do_reset;
        rchk(A_MD, 8'h40);
        rchk(A_CH, 8'h00);
        // lock keeps the watchdog on, then a forced reset
        wr(A_MD, 8'h00);
        wr(A_MD, 8'h20);
        @(negedge clk_i);
        chk({15'h0, wd_enabled_o}, 16'h0001);
        wr(A_MD, 8'h00);
        @(negedge clk_i);
        chk({15'h0, wd_enabled_o}, 16'h0001);
        wr(A_CTL, 8'h04);
        n = 0;
        while (wd_reset_o !== 1'b1 && n < 3) begin
            @(negedge clk_i);
            n++;
        end
        chk({15'h0, wd_reset_o}, 16'h0001);
        do_reset;
        give_verdict;
    end
endmodule
`default_nettype wire
